// >>> common/adcsp_pkg.sv
// =====================================================================
// shared constants of the converter serial link
package adcsp_pkg;
  // clock and link timing
  localparam int SYS_CLK_PERIOD_NS = 5;
  localparam int SCLK_HALF_NS      = 40;
  localparam int SCLK_HALF_CYC     = (SCLK_HALF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int INT_HALF_NS       = 40;
  localparam int INT_HALF_CYC      = (INT_HALF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  // frame layout
  localparam int WORD_BITS         = 32;
  localparam logic [5:0] MIN_WRITE_CLKS = 6'h20;
  localparam logic [5:0] SINGLE_STEPS   = 6'h20;
  localparam logic [5:0] DUAL_STEPS     = 6'h10;
  localparam int OP_MSB            = 31;
  localparam int ADDR_MSB          = 23;
  // commands: [31:24] opcode, [23:16] register, [15:0] data
  localparam logic [7:0] OP_WRITE  = 8'h0A;
  localparam logic [7:0] OP_READ   = 8'h05;
  // device register addresses
  localparam logic [7:0] ADDR_IN_CTL  = 8'h08;
  localparam logic [7:0] ADDR_OUT_CTL = 8'h0C;
  // output control fields
  localparam int OC_PROTO_LSB      = 0;
  localparam int OC_SYNC_SRC_BIT   = 6;
  localparam int OC_LANE_LSB       = 8;
  localparam logic [15:0] OC_MASK  = 16'h0343;
  localparam logic [1:0] LANE_DUAL = 2'h3;
  localparam logic [1:0] PROTO_SPI = 2'h0;
  // reset values
  localparam logic [1:0]  IN_CTL_RST  = 2'h0;
  localparam logic [15:0] OUT_CTL_RST = 16'h0000;
  // host register port (byte offsets)
  localparam logic [3:0] HR_CTRL   = 4'h0;
  localparam logic [3:0] HR_TX     = 4'h4;
  localparam logic [3:0] HR_RX     = 4'h8;
  localparam logic [3:0] HR_STATUS = 4'hC;
  localparam int HC_MODE_LSB       = 0;
  localparam int HC_PROTO_LSB      = 2;
  localparam int HC_DUAL_BIT       = 4;
  localparam int HC_LEN_LSB        = 8;
  localparam logic [5:0] HC_LEN_RST = 6'h20;
endpackage

// >>> common/adcsp_link_if.sv
`timescale 1ns/1ps
// =====================================================================
// serial link between host controller and converter
interface adcsp_link_if;
  logic cs_n;   // convert_select_pin, active low
  logic sclk;   // host serial clock
  logic sdi;    // host to device data
  logic sdo0;   // data_out_lane_zero
  logic sdo1;   // alarm_or_lane_one_pin
  logic ready_strobe_clock_out;    // ready_strobe_clock_out
  modport dev  (input cs_n, sclk, sdi, output sdo0, sdo1, ready_strobe_clock_out);
  modport host (output cs_n, sclk, sdi, input sdo0, sdo1, ready_strobe_clock_out);
endinterface

// >>> verilog/adcsp_device.sv
`timescale 1ns/1ps
// =====================================================================
// device end: shifts commands in, data out, keeps the mode registers
// How it works
// RQ1 - writes always use an edge mode frame
// RQ2 - mode value sets idle level, capture edge
// RQ3 - reset selects idle low, rising capture
// RQ4 - new mode applies from the next frame
// RQ5 - one mode governs reads and writes
// RQ6 - host gives at least 32 clocks per write
// RQ7 - msb at select fall or first clock edge
// RQ8 - host sets read protocol zero for edge reads
// RQ9 - strobe stays low in edge modes
// RQ10 - short frames are tolerated
// RQ11 - long frames shift through like a chain
// RQ12 - lane config 11b turns alarm pin to data
// RQ13 - dual lanes launch two bits per edge
// RQ14 - dual lanes keep timing, half the clocks
// RQ15 - sync modes drive clock on strobe pin
// RQ16 - source bit picks host or internal clock
// RQ17 - sync modes also support dual lanes
// RQ18 - commands act at select rise
// RQ19 - frame content set by previous command
// RQ20 - lane one carries the upper bit
// RQ21 - data goes out msb first
module adcsp_device
  import adcsp_pkg::*;
#(
  parameter int INT_HALF = INT_HALF_CYC    // internal strobe clock half period
)(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  // link
  adcsp_link_if.dev        link,
  // user side
  input  wire logic [15:0] conv_data_in,   // latest conversion result
  input  wire logic        alarm_in,       // alarm level for the shared pin
  output logic [1:0]       host_edge_mode_select_out,
  output logic [1:0]       read_protocol_select_out,
  output logic             dual_lane_out,
  output logic             sync_clock_source_select_out,
  output logic             frame_active_out
);

  // =====================================================================
  // state
  typedef struct packed {
    logic [1:0]  cs_s;       // select synchroniser
    logic [1:0]  sck_s;      // clock synchroniser
    logic [1:0]  sdi_s;      // data synchroniser
    logic        cs_d;       // delayed synced select
    logic        sck_d;      // delayed synced clock
    logic [1:0]  in_mode;    // input_control_register mode field
    logic [15:0] out_ctl;    // output_control_register
    logic [1:0]  fr_mode;    // mode frozen for the frame
    logic        fr_src;     // frame uses source synchronous mode
    logic        fr_int;     // frame strobe from internal clock
    logic        fr_dual;    // frame uses two lanes
    logic [31:0] sr;         // output shift register
    logic [31:0] rx;         // input shift register
    logic [5:0]  cnt;        // captured clocks, saturating
    logic        first;      // first launch edge still to come
    logic [5:0]  left;       // internal strobe rises still to give
    logic [7:0]  div;        // internal clock divider
    logic        ready_strobe_clock_out;        // strobe pin
    logic        sdo0;       // lane zero pin
    logic        sdo1;       // lane one pin
    logic [31:0] next_word;  // word for the next frame
  } adcsp_dev_s;

  adcsp_dev_s st_r;
  adcsp_dev_s st_nxt;

  // =====================================================================
  // helpers
  // pins shown for a shift register value; upper bit on lane one
  function automatic logic [1:0] lane_bits(input logic [31:0] v, input logic dual);
    lane_bits = dual ? v[31:30] : {1'b0, v[31]};  // [RQ20] [RQ21]
  endfunction

  // capture edge is rising when idle level and phase bits match
  function automatic logic cap_on_rise(input logic [1:0] m);
    cap_on_rise = (m[1] == m[0]);  // [RQ2]
  endfunction

  // combinational event flags
  logic        cs_fall;
  logic        cs_rise;
  logic        sck_rise;
  logic        sck_fall;
  logic        active;
  logic        cap;
  logic        launch;
  logic        shift;
  logic        int_fall;
  logic [1:0]  pins;
  logic [15:0] rd_val;
  logic        dual_cfg;

  // =====================================================================
  // next state
  always_comb
  begin
    st_nxt = st_r;
    // two flops before any use of a pin
    st_nxt.cs_s  = {st_r.cs_s[0], link.cs_n};
    st_nxt.sck_s = {st_r.sck_s[0], link.sclk};
    st_nxt.sdi_s = {st_r.sdi_s[0], link.sdi};
    st_nxt.cs_d  = st_r.cs_s[1];
    st_nxt.sck_d = st_r.sck_s[1];
    cs_fall  = st_r.cs_d & ~st_r.cs_s[1];
    cs_rise  = ~st_r.cs_d & st_r.cs_s[1];
    sck_rise = ~st_r.sck_d & st_r.sck_s[1];
    sck_fall = st_r.sck_d & ~st_r.sck_s[1];
    active   = ~st_r.cs_s[1] & ~cs_fall;
    // capture follows the frozen mode in every frame
    cap      = active & (cap_on_rise(st_r.fr_mode) ? sck_rise : sck_fall);  // [RQ5] [RQ1]
    launch   = active & (cap_on_rise(st_r.fr_mode) ? sck_fall : sck_rise);
    int_fall = 1'b0;
    shift    = 1'b0;
    pins     = lane_bits(st_r.sr, st_r.fr_dual);
    dual_cfg = (st_r.out_ctl[OC_LANE_LSB +: 2] == LANE_DUAL);  // [RQ12]
    rd_val   = 16'h0000;

    if (cs_fall)
    begin
      // freeze the mode set by earlier frames
      st_nxt.fr_mode = st_r.in_mode;  // [RQ4]
      st_nxt.fr_src  = (st_r.out_ctl[OC_PROTO_LSB +: 2] != PROTO_SPI);
      st_nxt.fr_int  = st_r.out_ctl[OC_SYNC_SRC_BIT];  // [RQ16]
      st_nxt.fr_dual = dual_cfg;
      st_nxt.sr      = st_r.next_word;  // [RQ19]
      st_nxt.cnt     = 6'h00;
      st_nxt.first   = 1'b1;
      st_nxt.div     = 8'h00;
      st_nxt.ready_strobe_clock_out     = 1'b0;
      st_nxt.left    = dual_cfg ? DUAL_STEPS : SINGLE_STEPS;
      pins           = lane_bits(st_r.next_word, dual_cfg);
      // phase zero and sync modes show the msb at select fall
      if (st_r.in_mode[0] == 1'b0 || st_r.out_ctl[OC_PROTO_LSB +: 2] != PROTO_SPI)
      begin
        st_nxt.sdo0 = pins[0];  // [RQ7]
        st_nxt.sdo1 = pins[1];
      end
      else
      begin
        st_nxt.sdo0 = 1'b0;
        st_nxt.sdo1 = 1'b0;
      end
    end
    else if (active)
    begin
      // commands always come in on the capture edge
      if (cap)
      begin
        st_nxt.rx = {st_r.rx[30:0], st_r.sdi_s[1]};
        if (st_r.cnt != 6'h3F)
        begin
          st_nxt.cnt = st_r.cnt + 6'h01;
        end
      end
      // strobe clock and shift timing per protocol
      if (!st_r.fr_src)
      begin
        st_nxt.ready_strobe_clock_out = 1'b0;  // [RQ9]
        shift      = launch;
      end
      else if (!st_r.fr_int)
      begin
        // strobe copies host clock so it rises on the capture edge; phase one
        // modes idle with the strobe high, so hold it low until the first launch
        st_nxt.ready_strobe_clock_out = (cap_on_rise(st_r.fr_mode) ? st_r.sck_s[1] : ~st_r.sck_s[1])
                     & ~(st_r.first & st_r.fr_mode[0]);  // [RQ15] [RQ16]
        shift      = launch;
      end
      else
      begin
        // internal divider; stops low once all steps are given
        if (st_r.div == 8'(INT_HALF - 1))
        begin
          st_nxt.div = 8'h00;
          if (st_r.ready_strobe_clock_out)
          begin
            st_nxt.ready_strobe_clock_out = 1'b0;  // [RQ15]
            int_fall   = 1'b1;
          end
          else if (st_r.left != 6'h00)
          begin
            st_nxt.ready_strobe_clock_out  = 1'b1;
            st_nxt.left = st_r.left - 6'h01;  // [RQ17]
          end
        end
        else
        begin
          st_nxt.div = st_r.div + 8'h01;
        end
        shift = int_fall;
      end
      if (shift)
      begin
        if (st_r.first && st_r.fr_mode[0] && !(st_r.fr_src && st_r.fr_int))
        begin
          // phase one: first launch edge presents the msb; internal strobe shifts from the start
          pins = lane_bits(st_r.sr, st_r.fr_dual);  // [RQ7]
        end
        else if (st_r.fr_dual)
        begin
          // two bits per launch edge; the same edges as one lane
          st_nxt.sr = {st_r.sr[29:0], 1'b0, st_r.rx[0]};  // [RQ13] [RQ14]
          pins      = lane_bits(st_nxt.sr, 1'b1);
        end
        else
        begin
          // captured bits follow the word out: chain behaviour
          st_nxt.sr = {st_r.sr[30:0], st_r.rx[0]};  // [RQ11] [RQ21]
          pins      = lane_bits(st_nxt.sr, 1'b0);
        end
        st_nxt.first = 1'b0;
        st_nxt.sdo0  = pins[0];
        st_nxt.sdo1  = pins[1];
      end
    end
    else if (cs_rise)
    begin
      // frame end: short frames simply stop here
      st_nxt.sdo0 = 1'b0;  // [RQ10]
      st_nxt.sdo1 = 1'b0;
      st_nxt.ready_strobe_clock_out  = 1'b0;
      st_nxt.next_word = {conv_data_in, 16'h0000};
      // commands need a full word of clocks to count
      if (st_r.cnt >= MIN_WRITE_CLKS)  // [RQ6]
      begin
        if (st_r.rx[OP_MSB -: 8] == OP_WRITE)
        begin
          if (st_r.rx[ADDR_MSB -: 8] == ADDR_IN_CTL)
          begin
            st_nxt.in_mode = st_r.rx[1:0];  // [RQ18] [RQ4]
          end
          else if (st_r.rx[ADDR_MSB -: 8] == ADDR_OUT_CTL)
          begin
            st_nxt.out_ctl = st_r.rx[15:0] & OC_MASK;  // [RQ18]
          end
        end
        else if (st_r.rx[OP_MSB -: 8] == OP_READ)
        begin
          if (st_r.rx[ADDR_MSB -: 8] == ADDR_IN_CTL)
          begin
            rd_val = {14'h0000, st_r.in_mode};
          end
          else if (st_r.rx[ADDR_MSB -: 8] == ADDR_OUT_CTL)
          begin
            rd_val = st_r.out_ctl;
          end
          st_nxt.next_word = {rd_val, 16'h0000};  // [RQ19]
        end
      end
    end
    // alarm owns the shared pin unless two lanes are configured
    if (!dual_cfg && !(cs_fall && st_r.out_ctl[OC_LANE_LSB +: 2] == LANE_DUAL))
    begin
      st_nxt.sdo1 = alarm_in;  // [RQ12]
    end
  end

  // =====================================================================
  // registers
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      st_r           <= '0;
      st_r.cs_s      <= 2'h3;
      st_r.cs_d      <= 1'b1;
      st_r.in_mode   <= IN_CTL_RST;  // [RQ3]
      st_r.out_ctl   <= OUT_CTL_RST;
      st_r.fr_mode   <= IN_CTL_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // =====================================================================
  // outputs
  assign link.sdo0 = st_r.sdo0;
  assign link.sdo1 = st_r.sdo1;
  assign link.ready_strobe_clock_out  = st_r.ready_strobe_clock_out;
  assign host_edge_mode_select_out    = st_r.in_mode;
  assign read_protocol_select_out     = st_r.out_ctl[OC_PROTO_LSB +: 2];
  assign dual_lane_out                = (st_r.out_ctl[OC_LANE_LSB +: 2] == LANE_DUAL);
  assign sync_clock_source_select_out = st_r.out_ctl[OC_SYNC_SRC_BIT];
  assign frame_active_out             = ~st_r.cs_d;

endmodule // adcsp_device

// >>> verilog/adcsp_host.sv
`timescale 1ns/1ps
// =====================================================================
// host end: drives select and clock, shifts words out and in
module adcsp_host
  import adcsp_pkg::*;
#(
  parameter int HALF = SCLK_HALF_CYC   // serial clock half period in cycles
)(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  // link
  adcsp_link_if.host       link,
  // register port
  input  wire logic [3:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [31:0]      rdata_out
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,   // select high
    ST_RUN  = 4'b0010,   // clock edges running
    ST_TAIL = 4'b0100,   // last half period, wait for strobe bits
    ST_GAP  = 4'b1000    // select high before next frame
  } adcsp_hst_e;

  typedef struct packed {
    adcsp_hst_e  state;
    logic [1:0]  mode;    // edge mode used for frames
    logic [1:0]  proto;   // read protocol the device is set to
    logic        dual;    // device uses two lanes
    logic [5:0]  len;     // clock cycles per frame
    logic [31:0] sh;      // outgoing word
    logic [31:0] rx;      // incoming word
    logic [5:0]  rxn;     // strobe captures seen
    logic [6:0]  edges;   // clock edges given
    logic [7:0]  div;     // half period counter
    logic        busy;
    logic        done;    // sticky, cleared by status read
    logic        cs_n;
    logic        sclk;
    logic [1:0]  s0_s;    // lane zero synchroniser
    logic [1:0]  s1_s;    // lane one synchroniser
    logic [1:0]  rv_s;    // strobe synchroniser
    logic        rv_d;
    logic [31:0] rdata;
  } adcsp_hst_s;

  adcsp_hst_s st_r;
  adcsp_hst_s st_nxt;

  // shift one or two received bits in
  function automatic logic [31:0] take(input logic [31:0] v, input logic dual, input logic b1, input logic b0);
    take = dual ? {v[29:0], b1, b0} : {v[30:0], b0};
  endfunction

  logic half_done;
  logic cap_edge;
  logic set_done;

  // =====================================================================
  // next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s0_s = {st_r.s0_s[0], link.sdo0};
    st_nxt.s1_s = {st_r.s1_s[0], link.sdo1};
    st_nxt.rv_s = {st_r.rv_s[0], link.ready_strobe_clock_out};
    st_nxt.rv_d = st_r.rv_s[1];
    half_done   = (st_r.div == 8'(HALF - 1));
    cap_edge    = 1'b0;
    set_done    = 1'b0;
    st_nxt.div  = half_done ? 8'h00 : st_r.div + 8'h01;
    // strobe rises mark data in sync modes
    if (!st_r.cs_n && st_r.proto != PROTO_SPI && st_r.rv_s[1] && !st_r.rv_d)
    begin
      st_nxt.rx  = take(st_r.rx, st_r.dual, st_r.s1_s[1], st_r.s0_s[1]);
      st_nxt.rxn = st_r.rxn + 6'h01;
    end
    case (st_r.state)
      ST_IDLE:
      begin
        st_nxt.div = 8'h00;
      end
      ST_RUN:
      begin
        if (half_done)
        begin
          st_nxt.sclk  = ~st_r.sclk;
          st_nxt.edges = st_r.edges + 7'h01;
          // phase zero captures on odd edges, phase one on even
          cap_edge = (st_r.edges[0] == st_r.mode[0]);  // [RQ2]
          if (cap_edge && st_r.proto == PROTO_SPI)
          begin
            st_nxt.rx = take(st_r.rx, st_r.dual, st_r.s1_s[1], st_r.s0_s[1]);  // [RQ14]
          end
          if (!cap_edge && !(st_r.mode[0] && st_r.edges == 7'h00))
          begin
            st_nxt.sh = {st_r.sh[30:0], 1'b0};
          end
          if (st_r.edges + 7'h01 == {st_r.len, 1'b0})
          begin
            st_nxt.state = ST_TAIL;  // [RQ6] [RQ10]
          end
        end
      end
      ST_TAIL:
      begin
        if (half_done && (st_r.proto == PROTO_SPI || st_r.rxn >= st_r.len))
        begin
          st_nxt.cs_n  = 1'b1;  // [RQ18]
          st_nxt.state = ST_GAP;
        end
        else if (half_done)
        begin
          st_nxt.div = 8'(HALF - 1);
        end
      end
      ST_GAP:
      begin
        if (half_done)
        begin
          st_nxt.busy  = 1'b0;
          set_done     = 1'b1;
          st_nxt.state = ST_IDLE;
        end
      end
      default:
      begin
        st_nxt.state = ST_IDLE;
      end
    endcase
    // register port
    st_nxt.rdata = 32'h0000_0000;
    if (wr_in && addr_in == HR_CTRL && !st_r.busy)
    begin
      st_nxt.mode  = wdata_in[HC_MODE_LSB +: 2];
      st_nxt.proto = wdata_in[HC_PROTO_LSB +: 2];  // [RQ8]
      st_nxt.dual  = wdata_in[HC_DUAL_BIT];
      st_nxt.len   = wdata_in[HC_LEN_LSB +: 6];
    end
    if (wr_in && addr_in == HR_TX && !st_r.busy && st_r.state == ST_IDLE)
    begin
      // start a frame; phase zero shows the msb at select fall
      st_nxt.sh    = wdata_in;  // [RQ1] [RQ5]
      st_nxt.rx    = 32'h0000_0000;
      st_nxt.rxn   = 6'h00;
      st_nxt.edges = 7'h00;
      st_nxt.div   = 8'h00;
      st_nxt.cs_n  = 1'b0;
      st_nxt.sclk  = st_r.mode[1];
      st_nxt.busy  = 1'b1;
      st_nxt.state = ST_RUN;
    end
    if (rd_in)
    begin
      case (addr_in)
        HR_CTRL:   st_nxt.rdata = {18'h0_0000, st_r.len, 3'h0, st_r.dual, st_r.proto, st_r.mode};
        HR_TX:     st_nxt.rdata = st_r.sh;
        HR_RX:     st_nxt.rdata = st_r.rx;
        HR_STATUS: st_nxt.rdata = {30'h0000_0000, st_r.done, st_r.busy};
        default:   st_nxt.rdata = 32'h0000_0000;
      endcase
      if (addr_in == HR_STATUS)
      begin
        st_nxt.done = 1'b0;
      end
    end
    // completion set wins over the read clear
    if (set_done)
    begin
      st_nxt.done = 1'b1;
    end
  end

  // =====================================================================
  // registers
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      st_r       <= '0;
      st_r.state <= ST_IDLE;
      st_r.len   <= HC_LEN_RST;
      st_r.cs_n  <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // =====================================================================
  // outputs
  assign link.cs_n = st_r.cs_n;
  assign link.sclk = st_r.sclk;
  assign link.sdi  = st_r.sh[31];
  assign rdata_out = st_r.rdata;

endmodule // adcsp_host

// >>> tb/adcsp_link_asserts.sv
`timescale 1ns/1ps
// =====================================================================
// link checker: watches the wires between host and device
module adcsp_link_asserts
  import adcsp_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk_in,
  input wire logic       rstn_in,
  // link wires
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic       sdo0,
  input wire logic       sdo1,
  input wire logic       ready_strobe_clock_out,
  // device side
  input wire logic       alarm_in,
  input wire logic [1:0] host_edge_mode_select_out,
  input wire logic [1:0] read_protocol_select_out,
  input wire logic       dual_lane_out,
  input wire logic       sync_clock_source_select_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  logic [5:0] idle_cnt_r;  // cycles of select high, saturating
  logic [6:0] edge_cnt_r;  // clock toggles inside the frame
  // =====================================================================
  // helper counters; an odd toggle count means the frame ended mid-period
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in || !cs_n) idle_cnt_r <= 6'h00;
    else if (idle_cnt_r != 6'h3F) idle_cnt_r <= idle_cnt_r + 6'h01;
    if (!rstn_in || cs_n) edge_cnt_r <= 7'h00;
    else if ($changed(sclk) && !$fell(cs_n)) edge_cnt_r <= edge_cnt_r + 7'h01;  // idle level move at select fall is no edge
  end
  // =====================================================================
  // assertions
  a_cs_fall_idle: assert property ($fell(cs_n) |-> sclk == host_edge_mode_select_out[1])
    else $error("serial clock not at idle level when select falls");
  a_edges_paired: assert property ($rose(cs_n) |-> !edge_cnt_r[0])
    else $error("frame ended with serial clock away from idle");
  a_sclk_half_period: assert property (!cs_n && $changed(sclk) |=> $stable(sclk) [*7])
    else $error("serial clock half period shorter than expected");
  a_rvs_low_spi: assert property (!cs_n && $past(!cs_n, 4) && read_protocol_select_out == PROTO_SPI |-> !ready_strobe_clock_out)
    else $error("strobe not low during edge mode frame");
  a_alarm_pass: assert property (!dual_lane_out && $stable(dual_lane_out) && $past(rstn_in) |-> sdo1 == $past(alarm_in))
    else $error("shared pin does not show alarm in single lane mode");
  a_mode_at_rise: assert property (!$stable(host_edge_mode_select_out) |-> cs_n && $past(cs_n, 2))
    else $error("edge mode changed inside a frame");
  a_ctl_at_rise: assert property (!$stable({read_protocol_select_out, dual_lane_out, sync_clock_source_select_out}) |-> cs_n && $past(cs_n, 2))
    else $error("output control changed inside a frame");
  a_sdo0_rest: assert property (idle_cnt_r > 6'h10 |-> !sdo0)
    else $error("lane zero not low between frames");
  // main scenarios
  c_sync_frame: cover property ($fell(cs_n) && read_protocol_select_out != PROTO_SPI);
  c_dual_frame: cover property ($fell(cs_n) && dual_lane_out);
  c_rvs_rise: cover property ($rose(ready_strobe_clock_out));
endmodule // adcsp_link_asserts

// >>> tb/tb_adc_serial_transfer_protocols.sv
`timescale 1ns/1ps
// =====================================================================
// bench: host and device face each other, driven from the register port
module tb_adc_serial_transfer_protocols;
  import adcsp_pkg::*;
  typedef struct packed {logic [31:0] c; logic [31:0] t; logic [31:0] r; logic [1:0] m;} adcsp_row_s;
  logic        sys_clk_in   = 1'b0;
  logic        rstn_in      = 1'b0;
  logic [3:0]  addr_in      = 4'h0;
  logic [31:0] wdata_in     = 32'h0000_0000;
  logic        wr_in        = 1'b0;
  logic        rd_in        = 1'b0;
  logic [31:0] rdata_out;
  logic [15:0] conv_data_in = 16'hA5C3;  // fixed so expected words are simple
  logic        alarm_in     = 1'b0;
  logic [1:0]  mode_w;
  logic [1:0]  proto_w;
  logic        dual_w;
  logic        src_w;
  logic        act_w;
  int          mismatches   = 0;
  int          n_compared   = 0;
  logic [31:0] d;                         // last register read
  adcsp_row_s  rows [15];                 // ctrl, tx word, expected rx, mode after
  always #2.5 sys_clk_in = ~sys_clk_in;
  adcsp_link_if link ();
  adcsp_host adcsp_host_inst (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .link(link), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out));
  adcsp_device adcsp_device_inst (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .link(link),
    .conv_data_in(conv_data_in), .alarm_in(alarm_in), .host_edge_mode_select_out(mode_w),
    .read_protocol_select_out(proto_w), .dual_lane_out(dual_w), .sync_clock_source_select_out(src_w),
    .frame_active_out(act_w));
  adcsp_link_asserts adcsp_link_asserts_inst (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .cs_n(link.cs_n),
    .sclk(link.sclk), .sdo0(link.sdo0), .sdo1(link.sdo1), .ready_strobe_clock_out(link.ready_strobe_clock_out), .alarm_in(alarm_in),
    .host_edge_mode_select_out(mode_w), .read_protocol_select_out(proto_w), .dual_lane_out(dual_w),
    .sync_clock_source_select_out(src_w));
  // =====================================================================
  // tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk_in);
    addr_in  <= a;
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    wr_in    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    rd_in   <= 1'b0;
    #1;
    d = rdata_out;
  endtask
  // one frame: set up, start, poll until idle, fetch the received word
  task automatic frame(input logic [31:0] c, input logic [31:0] t);
    int i;
    wr(HR_CTRL, c);
    wr(HR_TX, t);
    for (i = 0; i < 1000; i++)
    begin
      rd(HR_STATUS);
      if (d[0] === 1'b0) break;
    end
    if (i == 1000)
    begin
      mismatches++;
      $display("ERROR %0t frame never finished", $time);
      tally_and_finish();
    end
    rd(HR_RX);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // =====================================================================
  // main sequence
  initial
  begin
    rows = '{'{32'h0000_2000, 32'h0A08_0001, 32'hA5C3_0000, 2'h1}, '{32'h0000_2001, 32'h0508_0000, 32'hA5C3_0000, 2'h1},
             '{32'h0000_2001, 32'h0A08_0002, 32'h0001_0000, 2'h2}, '{32'h0000_2002, 32'h0A08_0003, 32'hA5C3_0000, 2'h3},
             '{32'h0000_2003, 32'h0508_0000, 32'hA5C3_0000, 2'h3}, '{32'h0000_2003, 32'h0000_0000, 32'h0003_0000, 2'h3},
             '{32'h0000_0803, 32'h0A08_0000, 32'h0000_00A5, 2'h3}, '{32'h0000_2003, 32'h0A0C_0041, 32'hA5C3_0000, 2'h3},
             '{32'h0000_2007, 32'h050C_0000, 32'hA5C3_0000, 2'h3}, '{32'h0000_2007, 32'h0A0C_0001, 32'h0041_0000, 2'h3},
             '{32'h0000_2007, 32'h0A0C_0301, 32'hA5C3_0000, 2'h3}, '{32'h0000_1017, 32'h0000_0000, 32'hA5C3_0000, 2'h3},
             '{32'h0000_2017, 32'h0A0C_0000, 32'h0044_0050, 2'h3}, '{32'h0000_2003, 32'h0A08_0000, 32'hA5C3_0000, 2'h0},
             '{32'h0000_2800, 32'h5A00_0000, 32'hC300_005A, 2'h0}};
    repeat (5) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
    chk({31'h0, link.cs_n}, 32'h0000_0001);
    chk({30'h0, mode_w}, 32'h0000_0000);
    chk({31'h0, act_w}, 32'h0000_0000);
    $display("reset test done");
    // first word after reset is zero, not a conversion result, so this frame is not checked
    frame(32'h0000_2000, 32'h0000_0000);
    for (int k = 0; k < 15; k++)
    begin
      // full writes in dual mode read back chain pairs of zero and a command bit
      frame(rows[k].c, rows[k].t);
      chk(d, rows[k].r);
      chk({30'h0, mode_w}, {30'h0, rows[k].m});
      if (k == 7) chk({28'h0, proto_w, dual_w, src_w}, 32'h0000_0005);
      if (k == 10) chk({28'h0, proto_w, dual_w, src_w}, 32'h0000_0006);
      $display("row %0d done", k);
    end
    // shared pin carries the alarm while single lane
    @(posedge sys_clk_in);
    alarm_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    #1;
    chk({31'h0, link.sdo1}, 32'h0000_0001);
    rd(4'h2);
    chk(d, 32'h0000_0000);
    $display("alarm and unmapped test done");
    // reset in mid-run drops a selected mode
    frame(32'h0000_2000, 32'h0A08_0002);
    chk({30'h0, mode_w}, 32'h0000_0002);
    @(posedge sys_clk_in);
    rstn_in <= 1'b0;
    repeat (5) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
    chk({30'h0, mode_w}, 32'h0000_0000);
    chk({31'h0, dual_w}, 32'h0000_0000);
    $display("second reset test done");
    tally_and_finish();
  end
endmodule // tb_adc_serial_transfer_protocols
